// ---- logic/egress_class_and_vlan_filter.sv ----
// Egress queue class selection and VLAN forwarding filter
//
// Local design decisions: register access over AXI4-Lite and the address map.
`timescale 1ns/10ps
// Contract
// - Ethernet egress class comes from the packet's traffic class.
// - Time-sensitive packets to enabled ports: priority 5 to class 5, 4 to 4.
// - Host uplink class is chosen from the to-host reasons.
// - Aggregation mode: host uplink class comes from the traffic class.
// - Without aggregation: host uplink class comes from the reasons.
// - Each reason has a programmable class, reset to 0.
// - Learning copy to host only while software learning is enabled.
// - Mirror copy to host when host is the mirror capture destination.
// - Layer-2 protocols to terminate are trapped to host.
// - Layer-3 or application protocols are copied to host for snooping.
// - Exceptions and flooding decisions trap the packet to host.
// - Host in the destinations gives the switching reason.
// - Several reasons: use the highest class among them.
// - Forwarding vector is ANDed with the ingress port's private mask.
// - About 4000-entry VLAN table looked up with every address lookup.
// - Tags are added or removed per egress port from the table.
// - Untag map bit set sends untagged, clear sends tagged.
// - Forward map restricts forwarding to VLAN members.
// - Forward-select flag picks VLAN membership or lookup result.
// - Untag and forward maps hold one bit per switch port.
// - Management MII port keeps the tag even with untag bit set.
// - Forward-select flag 1 forwards directly by the forward map.
// - Ethernet ports use classes 0 to 5; 4 and 5 only time-sensitive.
// - Host uplink egress serves only classes 0 to 3.
module egress_class_and_vlan_filter (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] awaddr,
    input wire logic wvalid,
    output logic wready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    output logic bvalid,
    input wire logic bready,
    output logic [1:0] bresp,
    // AXI4-Lite read
    input wire logic arvalid,
    output logic arready,
    input wire logic [31:0] araddr,
    output logic rvalid,
    input wire logic rready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    // Packet descriptors
    input wire egress_filter_pkg::pkt_in_t pkt_in,
    output egress_filter_pkg::pkt_out_t pkt_out
);

    // ************************************************************
    // Helpers
    // ************************************************************
    function automatic logic [2:0] host_clamp(input logic [2:0] c);
        return (c > egress_filter_pkg::CLS_HOST_MAX) ?
            egress_filter_pkg::CLS_HOST_MAX : c;
    endfunction

    function automatic logic [31:0] strb_merge(input logic [31:0] old,
                                               input logic [31:0] nw,
                                               input logic [3:0] s);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (s[i]) begin
                r[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return r;
    endfunction

    // ************************************************************
    // Registers
    // ************************************************************
    logic [3:0] ctrl_r;
    logic [egress_filter_pkg::NPORT-1:0] av_mask_r;
    logic [egress_filter_pkg::NREASON-1:0][2:0] reason_cls_r;
    logic [egress_filter_pkg::VID_W-1:0] vlan_idx_r;
    egress_filter_pkg::vlan_entry_t vlan_data_r;
    logic [2:0] pd_idx_r;
    logic [egress_filter_pkg::NPORT-1:0][egress_filter_pkg::NPORT-1:0] pd_r;
    egress_filter_pkg::vlan_entry_t
        vlan_tab_r [egress_filter_pkg::VLAN_ENTRIES];
    logic [15:0] pkt_cnt_r;

    logic aw_got_r, w_got_r, awready_r, wready_r, bvalid_r, awaddr_hi_ok_r;
    logic [1:0] bresp_r;
    logic [7:0] waddr_r;
    logic [31:0] wdata_r;
    logic [3:0] wstrb_r;
    logic arready_r, rvalid_r;
    logic [31:0] rdata_r;
    logic [1:0] rresp_r;
    egress_filter_pkg::pkt_out_t pkt_out_r;

    function automatic logic [31:0] reg_word(input logic [7:0] a);
        logic [31:0] v;
        v = 32'h0;
        case (a)
            egress_filter_pkg::A_CTRL: v[3:0] = ctrl_r;
            egress_filter_pkg::A_AV_MASK: v[6:0] = av_mask_r;
            egress_filter_pkg::A_REASON_CLS: v[17:0] = reason_cls_r;
            egress_filter_pkg::A_VLAN_IDX: v[11:0] = vlan_idx_r;
            egress_filter_pkg::A_VLAN_DATA: begin
                v[egress_filter_pkg::F_UNTAG_LSB +: 7] = vlan_data_r.untag_map;
                v[egress_filter_pkg::F_FWD_LSB +: 7] = vlan_data_r.fwd_map;
                v[egress_filter_pkg::F_SEL_BIT] = vlan_data_r.fwd_select_flag;
            end
            egress_filter_pkg::A_VLAN_CMD: v = 32'h0;
            egress_filter_pkg::A_PD_IDX: v[2:0] = pd_idx_r;
            egress_filter_pkg::A_PD_MASK: v[6:0] = pd_r[pd_idx_r];
            egress_filter_pkg::A_STATUS: v[15:0] = pkt_cnt_r;
            default: v = 32'h0;
        endcase
        return v;
    endfunction

    function automatic logic mapped(input logic [7:0] a);
        return a <= egress_filter_pkg::A_STATUS && a[1:0] == 2'h0;
    endfunction

    // ************************************************************
    // AXI4-Lite write channel
    // ************************************************************
    logic aw_take, w_take, do_write, aw_got_nxt, w_got_nxt, bvalid_nxt;
    logic [31:0] wword;
    assign aw_take = awvalid & awready_r;
    assign w_take = wvalid & wready_r;
    assign do_write = aw_got_r & w_got_r & ~bvalid_r;
    assign aw_got_nxt = (aw_got_r & ~do_write) | aw_take;
    assign w_got_nxt = (w_got_r & ~do_write) | w_take;
    assign bvalid_nxt = do_write | (bvalid_r & ~bready);
    always_comb wword = strb_merge(reg_word(waddr_r), wdata_r, wstrb_r);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_got_r <= 1'b0;
            w_got_r <= 1'b0;
            awready_r <= 1'b0;
            wready_r <= 1'b0;
            bvalid_r <= 1'b0;
            bresp_r <= egress_filter_pkg::RESP_OKAY;
            waddr_r <= 8'h00;
            wdata_r <= 32'h0;
            wstrb_r <= 4'h0;
            awaddr_hi_ok_r <= 1'b0;
        end else begin
            aw_got_r <= aw_got_nxt;
            w_got_r <= w_got_nxt;
            awready_r <= ~aw_got_nxt & ~bvalid_nxt;
            wready_r <= ~w_got_nxt & ~bvalid_nxt;
            bvalid_r <= bvalid_nxt;
            if (aw_take) begin
                waddr_r <= awaddr[7:0];
                // Upper address bits must be zero for a hit
                awaddr_hi_ok_r <= awaddr[31:8] == 24'h0;
            end
            if (w_take) begin
                wdata_r <= wdata;
                wstrb_r <= wstrb;
            end
            if (do_write) begin
                bresp_r <= (mapped(waddr_r) && awaddr_hi_ok_r) ?
                    egress_filter_pkg::RESP_OKAY :
                    egress_filter_pkg::RESP_SLVERR;
            end
        end
    end

    logic wr_hit;
    assign wr_hit = do_write & mapped(waddr_r) & awaddr_hi_ok_r;

    // ************************************************************
    // Configuration registers
    // ************************************************************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_r <= 4'h0;
            av_mask_r <= 7'h00;
            reason_cls_r <= {egress_filter_pkg::NREASON{
                egress_filter_pkg::CLS_RESET}};
            vlan_idx_r <= 12'h000;
            pd_idx_r <= 3'h0;
        end else if (wr_hit) begin
            case (waddr_r)
                egress_filter_pkg::A_CTRL: ctrl_r <= wword[3:0];
                egress_filter_pkg::A_AV_MASK: av_mask_r <= wword[6:0];
                egress_filter_pkg::A_REASON_CLS:
                    reason_cls_r <= wword[17:0];
                egress_filter_pkg::A_VLAN_IDX: vlan_idx_r <= wword[11:0];
                egress_filter_pkg::A_PD_IDX: pd_idx_r <= wword[2:0];
                default: ;
            endcase
        end
    end

    // Private domains default to all ports so traffic flows after reset
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pd_r <= {egress_filter_pkg::NPORT{7'h7F}};
        end else if (wr_hit && waddr_r == egress_filter_pkg::A_PD_MASK) begin
            pd_r[pd_idx_r] <= wword[6:0];
        end
    end

    // ************************************************************
    // VLAN table access
    // ************************************************************
    logic cmd_wr, cmd_rd;
    assign cmd_wr = wr_hit && waddr_r == egress_filter_pkg::A_VLAN_CMD &&
        wword[egress_filter_pkg::B_CMD_WR];
    assign cmd_rd = wr_hit && waddr_r == egress_filter_pkg::A_VLAN_CMD &&
        wword[egress_filter_pkg::B_CMD_RD];

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            vlan_data_r <= '0;
        end else if (wr_hit && waddr_r == egress_filter_pkg::A_VLAN_DATA) begin
            vlan_data_r.untag_map <= wword[egress_filter_pkg::F_UNTAG_LSB +: 7];
            vlan_data_r.fwd_map <= wword[egress_filter_pkg::F_FWD_LSB +: 7];
            vlan_data_r.fwd_select_flag <= wword[egress_filter_pkg::F_SEL_BIT];
        end else if (cmd_rd) begin
            vlan_data_r <= vlan_tab_r[vlan_idx_r];
        end
    end

    // Table is not reset: software fills it before enabling traffic
    always_ff @(posedge aclk) begin
        if (cmd_wr) begin
            vlan_tab_r[vlan_idx_r] <= vlan_data_r;
        end
    end

    // ************************************************************
    // AXI4-Lite read channel
    // ************************************************************
    logic ar_take, rvalid_nxt;
    assign ar_take = arvalid & arready_r;
    assign rvalid_nxt = ar_take | (rvalid_r & ~rready);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_r <= 1'b0;
            rvalid_r <= 1'b0;
            rdata_r <= 32'h0;
            rresp_r <= egress_filter_pkg::RESP_OKAY;
        end else begin
            arready_r <= ~rvalid_nxt;
            rvalid_r <= rvalid_nxt;
            if (ar_take) begin
                rdata_r <= reg_word(araddr[7:0]);
                rresp_r <= (mapped(araddr[7:0]) && araddr[31:8] == 24'h0) ?
                    egress_filter_pkg::RESP_OKAY :
                    egress_filter_pkg::RESP_SLVERR;
            end
        end
    end

    // ************************************************************
    // Forwarding and class datapath
    // ************************************************************
    egress_filter_pkg::vlan_entry_t ent;
    logic [egress_filter_pkg::NPORT-1:0] vec, untag;
    logic [egress_filter_pkg::NREASON-1:0] rsn;
    logic [2:0] host_cls, tc_eth;
    logic [egress_filter_pkg::NPORT-1:0][2:0] cls;
    logic trap;

    always_comb begin
        ent = vlan_tab_r[pkt_in.vid];
        rsn = '0;
        // Traps steal the packet, copies only add the host
        trap = pkt_in.l2_term | pkt_in.exception | pkt_in.flood;
        if (ent.fwd_select_flag) begin
            vec = ent.fwd_map;
        end else begin
            vec = pkt_in.lookup_vec & ent.fwd_map;
        end
        vec = vec & pd_r[pkt_in.ingress_port];
        rsn[egress_filter_pkg::RS_SWITCH] =
            vec[egress_filter_pkg::HOST_PORT];
        rsn[egress_filter_pkg::RS_MIRROR] = pkt_in.mirror_req &
            ctrl_r[egress_filter_pkg::B_MIRROR_HOST];
        rsn[egress_filter_pkg::RS_LEARN] = pkt_in.learn_req &
            ctrl_r[egress_filter_pkg::B_SW_LEARN];
        rsn[egress_filter_pkg::RS_TERM] = pkt_in.l2_term;
        rsn[egress_filter_pkg::RS_SNOOP] = pkt_in.l3_snoop;
        rsn[egress_filter_pkg::RS_EXCEPT] =
            pkt_in.exception | pkt_in.flood;
        if (trap) begin
            vec = '0;
        end
        if (|rsn) begin
            vec[egress_filter_pkg::HOST_PORT] = 1'b1;
        end
        // Maximum over the classes of set reasons
        host_cls = egress_filter_pkg::CLS_RESET;
        for (int i = 0; i < egress_filter_pkg::NREASON; i++) begin
            if (rsn[i] && reason_cls_r[i] > host_cls) begin
                host_cls = reason_cls_r[i];
            end
        end
        if (ctrl_r[egress_filter_pkg::B_AGGR]) begin
            host_cls = host_clamp(pkt_in.traffic_class);
        end else begin
            host_cls = host_clamp(host_cls);
        end
        // Classes 4 and 5 stay free for time-sensitive traffic
        tc_eth = (pkt_in.traffic_class > egress_filter_pkg::CLS_ETH_MAX) ?
            egress_filter_pkg::CLS_ETH_MAX : pkt_in.traffic_class;
        for (int p = 0; p < egress_filter_pkg::NPORT; p++) begin
            cls[p] = tc_eth;
            if (pkt_in.time_sensitive && av_mask_r[p] &&
                (pkt_in.pcp == egress_filter_pkg::PCP_HI ||
                 pkt_in.pcp == egress_filter_pkg::PCP_LO)) begin
                cls[p] = pkt_in.pcp;
            end
        end
        cls[egress_filter_pkg::HOST_PORT] = host_cls;
        untag = ent.untag_map;
        if (ctrl_r[egress_filter_pkg::B_MII_MGMT]) begin
            untag[egress_filter_pkg::MII_PORT] = 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pkt_out_r <= '0;
        end else begin
            pkt_out_r.valid <= pkt_in.valid;
            pkt_out_r.egress_vec <= pkt_in.valid ? vec : '0;
            pkt_out_r.untag_vec <= untag;
            pkt_out_r.queue_class <= cls;
            pkt_out_r.to_host_reason <= pkt_in.valid ? rsn : '0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pkt_cnt_r <= 16'h0000;
        end else if (pkt_in.valid) begin
            pkt_cnt_r <= pkt_cnt_r + 16'h0001;
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    assign awready = awready_r;
    assign wready = wready_r;
    assign bvalid = bvalid_r;
    assign bresp = bresp_r;
    assign arready = arready_r;
    assign rvalid = rvalid_r;
    assign rdata = rdata_r;
    assign rresp = rresp_r;
    assign pkt_out = pkt_out_r;

endmodule // egress_class_and_vlan_filter

// ---- logic/egress_filter_pkg.sv ----
// Package: constants, register map and carriers of the egress filter
package egress_filter_pkg;
    localparam int NPORT = 7;
    localparam int HOST_PORT = 6;
    localparam int MII_PORT = 5;
    localparam int VLAN_ENTRIES = 4096;
    localparam int VID_W = 12;
    localparam int CLS_W = 3;
    localparam int NREASON = 6;
    // Register byte addresses
    localparam logic [7:0] A_CTRL = 8'h00;
    localparam logic [7:0] A_AV_MASK = 8'h04;
    localparam logic [7:0] A_REASON_CLS = 8'h08;
    localparam logic [7:0] A_VLAN_IDX = 8'h0C;
    localparam logic [7:0] A_VLAN_DATA = 8'h10;
    localparam logic [7:0] A_VLAN_CMD = 8'h14;
    localparam logic [7:0] A_PD_IDX = 8'h18;
    localparam logic [7:0] A_PD_MASK = 8'h1C;
    localparam logic [7:0] A_STATUS = 8'h20;
    // Control register and VLAN command bits
    localparam int B_AGGR = 0;
    localparam int B_SW_LEARN = 1;
    localparam int B_MIRROR_HOST = 2;
    localparam int B_MII_MGMT = 3;
    localparam int B_CMD_WR = 0;
    localparam int B_CMD_RD = 1;
    // VLAN data word layout
    localparam int F_UNTAG_LSB = 0;
    localparam int F_FWD_LSB = 8;
    localparam int F_SEL_BIT = 16;
    // Reason indices
    localparam int RS_MIRROR = 0;
    localparam int RS_LEARN = 1;
    localparam int RS_SWITCH = 2;
    localparam int RS_TERM = 3;
    localparam int RS_SNOOP = 4;
    localparam int RS_EXCEPT = 5;
    localparam logic [CLS_W-1:0] CLS_RESET = 3'h0;
    localparam logic [CLS_W-1:0] CLS_HOST_MAX = 3'h3;
    localparam logic [CLS_W-1:0] CLS_ETH_MAX = 3'h3;
    localparam logic [CLS_W-1:0] PCP_HI = 3'h5;
    localparam logic [CLS_W-1:0] PCP_LO = 3'h4;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic fwd_select_flag;
        logic [NPORT-1:0] fwd_map;
        logic [NPORT-1:0] untag_map;
    } vlan_entry_t;

    typedef struct packed {
        logic valid;
        logic [2:0] ingress_port;
        logic [NPORT-1:0] lookup_vec;
        logic [VID_W-1:0] vid;
        logic [CLS_W-1:0] traffic_class;
        logic [CLS_W-1:0] pcp;
        logic time_sensitive;
        logic learn_req;
        logic mirror_req;
        logic l2_term;
        logic l3_snoop;
        logic exception;
        logic flood;
    } pkt_in_t;

    typedef struct packed {
        logic valid;
        logic [NPORT-1:0] egress_vec;
        logic [NPORT-1:0] untag_vec;
        logic [NPORT-1:0][CLS_W-1:0] queue_class;
        logic [NREASON-1:0] to_host_reason;
    } pkt_out_t;
endpackage

// ---- sim/egress_class_and_vlan_filter_bench.sv ----
// Testbench of the egress class and VLAN filter
`timescale 1ns/10ps
module egress_class_and_vlan_filter_bench;
    import egress_filter_pkg::*;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic awvalid = 1'b0;
    logic wvalid = 1'b0;
    logic bready = 1'b0;
    logic arvalid = 1'b0;
    logic rready = 1'b0;
    logic [31:0] awaddr = 32'h0;
    logic [31:0] wdata = 32'h0;
    logic [31:0] araddr = 32'h0;
    logic [3:0] wstrb = 4'hF;
    logic awready, wready, bvalid, arready, rvalid, bad_cls;
    logic [1:0] bresp, rresp, resp;
    logic [31:0] rdata, rd_data;
    logic [15:0] host_cnt;
    pkt_in_t pkt_in = '0;
    pkt_out_t pkt_out, o;
    int failures = 0;
    int compares = 0;
    int host_exp = 0;

    initial begin
        forever #4 aclk = ~aclk;
    end

    egress_class_and_vlan_filter DUT (
        .aclk(aclk), .aresetn(aresetn), .awvalid(awvalid),
        .awready(awready), .awaddr(awaddr), .wvalid(wvalid),
        .wready(wready), .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid),
        .bready(bready), .bresp(bresp), .arvalid(arvalid),
        .arready(arready), .araddr(araddr), .rvalid(rvalid),
        .rready(rready), .rdata(rdata), .rresp(rresp),
        .pkt_in(pkt_in), .pkt_out(pkt_out)
    );
    host_sink u_sink (.aclk(aclk), .aresetn(aresetn), .pkt_out(pkt_out),
        .host_cnt(host_cnt), .bad_cls(bad_cls));

    // ****************
    // Helpers
    // ****************
    task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
        compares++;
        if (g !== e) begin
            failures++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wr(logic [7:0] a, logic [31:0] d);
        logic ad = 1'b0;
        logic dd = 1'b0;
        int n = 0;
        awaddr <= {24'h0, a};
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (!ad && awready) begin
                ad = 1'b1;
                awvalid <= 1'b0;
            end
            if (!dd && wready) begin
                dd = 1'b1;
                wvalid <= 1'b0;
            end
        end while (!bvalid && n < 64);
        resp = bresp;
        bready <= 1'b0;
        if (n >= 64) failures++;
    endtask
    task automatic rd(logic [7:0] a);
        logic ad = 1'b0;
        int n = 0;
        araddr <= {24'h0, a};
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (!ad && arready) begin
                ad = 1'b1;
                arvalid <= 1'b0;
            end
        end while (!rvalid && n < 64);
        rd_data = rdata;
        resp = rresp;
        rready <= 1'b0;
        if (n >= 64) failures++;
    endtask
    // Flags: learn, mirror, term, snoop, exception, flood
    task automatic pk(logic [2:0] pt, logic [6:0] lk, logic [11:0] v,
                      logic [2:0] tc, logic [2:0] pcp, logic ts,
                      logic [5:0] fl);
        pkt_in <= {1'b1, pt, lk, v, tc, pcp, ts, fl};
        @(posedge aclk);
        pkt_in <= '0;
        @(posedge aclk);
        o = pkt_out;
    endtask
    task automatic vl(logic [11:0] v, logic s, logic [6:0] f, logic [6:0] u);
        wr(A_VLAN_IDX, {20'h0, v});
        wr(A_VLAN_DATA, {15'h0, s, 1'b0, f, 1'b0, u});
        wr(A_VLAN_CMD, 32'h1);
    endtask
    task automatic row(logic [3:0] c, logic [5:0] fl, logic [6:0] lk,
                       logic [2:0] tc, logic [5:0] rs, logic [6:0] eg,
                       logic [2:0] cl);
        wr(A_CTRL, {28'h0, c});
        pk(3'h0, lk, 12'h1, tc, 3'h0, 1'b0, fl);
        host_exp += int'(eg[6]);
        chk("egress", eg, o.egress_vec);
        chk("reason", rs, o.to_host_reason);
        if (eg[6]) chk("host class", cl, o.queue_class[6]);
    endtask

    // ****************
    // Scenarios
    // ****************
    task automatic t_regs;
        rd(A_REASON_CLS);
        chk("reason cls", 32'h0, rd_data);
        rd(A_PD_MASK);
        chk("pd mask", 32'h7F, rd_data);
        rd(8'h40);
        chk("bad rd", RESP_SLVERR, resp);
        wr(8'h44, 32'h1);
        chk("bad wr", RESP_SLVERR, resp);
        // Mirror and learn kept lowest so one flow stays in order
        wr(A_REASON_CLS, 32'hA688);
        rd(A_REASON_CLS);
        chk("reason cls", 32'hA688, rd_data);
    endtask
    task automatic t_eth;
        logic [2:0] tc, e0, e1;
        vl(12'h1, 1'b0, 7'h7F, 7'h00);
        wr(A_AV_MASK, 32'h1);
        for (int t = 0; t < 16; t++) begin
            tc = t[2:0];
            pk(3'h0, 7'h1F, 12'h1, tc, tc, t[3], 6'h00);
            e1 = (tc > 3'h3) ? 3'h3 : tc;
            e0 = (t[3] && (tc == 3'h4 || tc == 3'h5)) ? tc : e1;
            chk("class av", e0, o.queue_class[0]);
            chk("class eth", e1, o.queue_class[1]);
        end
    endtask
    task automatic t_reasons;
        row(4'h0, 6'h20, 7'h02, 3'h0, 6'h00, 7'h02, 3'h0);
        row(4'h2, 6'h20, 7'h02, 3'h0, 6'h02, 7'h42, 3'h1);
        row(4'h0, 6'h10, 7'h02, 3'h0, 6'h00, 7'h02, 3'h0);
        row(4'h4, 6'h10, 7'h02, 3'h0, 6'h01, 7'h42, 3'h0);
        row(4'h0, 6'h00, 7'h42, 3'h0, 6'h04, 7'h42, 3'h2);
        row(4'h0, 6'h08, 7'h03, 3'h0, 6'h08, 7'h40, 3'h3);
        row(4'h2, 6'h24, 7'h02, 3'h0, 6'h12, 7'h42, 3'h2);
        row(4'h0, 6'h02, 7'h05, 3'h0, 6'h20, 7'h40, 3'h1);
        row(4'h0, 6'h01, 7'h05, 3'h0, 6'h20, 7'h40, 3'h1);
        row(4'h0, 6'h0A, 7'h05, 3'h0, 6'h28, 7'h40, 3'h3);
        row(4'h1, 6'h08, 7'h02, 3'h6, 6'h08, 7'h40, 3'h3);
        row(4'h1, 6'h08, 7'h02, 3'h2, 6'h08, 7'h40, 3'h2);
        row(4'h0, 6'h08, 7'h02, 3'h2, 6'h08, 7'h40, 3'h3);
    endtask
    task automatic t_vlan;
        wr(A_CTRL, 32'h0);
        vl(12'hFFF, 1'b0, 7'h0F, 7'h21);
        pk(3'h0, 7'h33, 12'hFFF, 3'h0, 3'h0, 1'b0, 6'h00);
        chk("member", 32'h03, o.egress_vec);
        chk("untag", 32'h21, o.untag_vec);
        wr(A_CTRL, 32'h8);
        pk(3'h0, 7'h33, 12'hFFF, 3'h0, 3'h0, 1'b0, 6'h00);
        chk("untag mgmt", 32'h01, o.untag_vec);
        vl(12'hFFF, 1'b1, 7'h0F, 7'h21);
        pk(3'h0, 7'h30, 12'hFFF, 3'h0, 3'h0, 1'b0, 6'h00);
        chk("direct", 32'h0F, o.egress_vec);
        wr(A_PD_IDX, 32'h2);
        wr(A_PD_MASK, 32'h05);
        pk(3'h2, 7'h30, 12'hFFF, 3'h0, 3'h0, 1'b0, 6'h00);
        chk("private", 32'h05, o.egress_vec);
        wr(A_VLAN_DATA, 32'h0);
        wr(A_VLAN_CMD, 32'h2);
        rd(A_VLAN_DATA);
        chk("entry", 32'h10F21, rd_data);
        rd(A_STATUS);
        chk("packet count", 32'h21, rd_data);
    endtask

    task automatic print_verdict;
        if (failures == 0 && compares > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    initial begin
        #100000;
        failures++;
        print_verdict();
    end
    initial begin
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        t_regs();
        t_eth();
        t_reasons();
        t_vlan();
        chk("host count", host_exp, {16'h0, host_cnt});
        chk("host queue", 32'h0, {31'h0, bad_cls});
        print_verdict();
    end
endmodule // egress_class_and_vlan_filter_bench

// ---- sim/egress_filter_monitor.sv ----
// Concurrent checks on the egress filter ports
`timescale 1ns/10ps
module egress_filter_monitor (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Register bus handshakes
    input wire logic awvalid,
    input wire logic awready,
    input wire logic wvalid,
    input wire logic wready,
    input wire logic bvalid,
    input wire logic arvalid,
    input wire logic arready,
    input wire logic rvalid,
    // Packet descriptors
    input wire egress_filter_pkg::pkt_in_t pkt_in,
    input wire egress_filter_pkg::pkt_out_t pkt_out
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // ****************
    // Steps
    // ****************
    sequence s_wr_take;
        awvalid && awready && wvalid && wready;
    endsequence
    sequence s_trap;
        pkt_in.valid && (pkt_in.l2_term || pkt_in.exception || pkt_in.flood);
    endsequence
    // ****************
    // Checks
    // ****************
    a_write_answer: assert property (
        s_wr_take |-> !bvalid ##1 !bvalid ##1 bvalid)
        else $error("write response late or early");
    a_read_answer: assert property (
        arvalid && arready |=> rvalid)
        else $error("read data not one cycle after address");
    a_pkt_latency: assert property (
        pkt_in.valid |=> pkt_out.valid)
        else $error("descriptor lost");
    a_pkt_quiet: assert property (
        !pkt_in.valid |=> !pkt_out.valid && pkt_out.to_host_reason == '0)
        else $error("output without input");
    a_host_cap: assert property (
        pkt_out.valid && pkt_out.egress_vec[6] |->
        pkt_out.queue_class[6] <= egress_filter_pkg::CLS_HOST_MAX)
        else $error("host class above three");
    a_eth_av_only: assert property (
        pkt_out.valid && !$past(pkt_in.time_sensitive) |->
        pkt_out.queue_class[0] <= 3'h3)
        else $error("audio class without time sensitive");
    a_trap_host_only: assert property (
        s_trap |=> pkt_out.egress_vec[5:0] == 6'h00)
        else $error("trapped packet left on a port");
    a_term_reason: assert property (
        pkt_in.valid |=> pkt_out.to_host_reason[3] == $past(pkt_in.l2_term))
        else $error("terminate reason wrong");
    a_snoop_reason: assert property (
        pkt_in.valid |=> pkt_out.to_host_reason[4] == $past(pkt_in.l3_snoop))
        else $error("snoop reason wrong");
    a_except_reason: assert property (
        s_trap |=> pkt_out.to_host_reason[5] || pkt_out.to_host_reason[3])
        else $error("trap without trap reason");
    a_learn_cause: assert property (
        pkt_out.to_host_reason[1] |-> $past(pkt_in.learn_req))
        else $error("learn reason without request");
    a_mirror_cause: assert property (
        pkt_out.to_host_reason[0] |-> $past(pkt_in.mirror_req))
        else $error("mirror reason without request");
    a_reason_host: assert property (
        pkt_out.valid && (|pkt_out.to_host_reason) |-> pkt_out.egress_vec[6])
        else $error("reason set but host not reached");
endmodule // egress_filter_monitor

bind egress_class_and_vlan_filter egress_filter_monitor u_mon (
    .aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready),
    .wvalid(wvalid), .wready(wready), .bvalid(bvalid), .arvalid(arvalid),
    .arready(arready), .rvalid(rvalid), .pkt_in(pkt_in), .pkt_out(pkt_out)
);

// ---- sim/host_sink.sv ----
// Management processor model on the host uplink
`timescale 1ns/10ps
module host_sink (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Traffic towards the processor
    input wire egress_filter_pkg::pkt_out_t pkt_out,
    // Observations
    output logic [15:0] host_cnt,
    output logic bad_cls
);
    localparam int HP = egress_filter_pkg::HOST_PORT;
    // Only four queues exist on this side
    localparam logic [2:0] QMAX = egress_filter_pkg::CLS_HOST_MAX;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            host_cnt <= 16'h0;
            bad_cls <= 1'b0;
        end else if (pkt_out.valid && pkt_out.egress_vec[HP]) begin
            host_cnt <= host_cnt + 16'h1;
            if (pkt_out.queue_class[HP] > QMAX) begin
                bad_cls <= 1'b1;
            end
        end
    end
endmodule // host_sink
